// >>> hdl/rtcai_pkg.sv
/*
 * Constants for the alarm, interrupt and special-register block of a
 * serial real-time clock: register offsets, field positions, reset values.
 * Assumes byte-wide register access from a serial engine elsewhere.
 */
package rtcai_pkg;

    // Pointer bit that marks a write address
    localparam int RTCAI_WR_BIT = 7;

    // Read offsets; the write address is the same with the write bit set
    localparam logic [6:0] RTCAI_OFS_ALM0 = 7'h07;
    localparam logic [6:0] RTCAI_OFS_ALM1 = 7'h0B;
    localparam logic [6:0] RTCAI_OFS_CTRL = 7'h0F;
    localparam logic [6:0] RTCAI_OFS_STAT = 7'h10;
    localparam logic [6:0] RTCAI_OFS_CHG = 7'h11;

    // Registers per alarm: seconds, minutes, hours, day
    localparam int RTCAI_ALM_REGS = 4;
    localparam logic [6:0] RTCAI_ALM_SPAN = 7'h04;
    localparam int RTCAI_ALM_SEC = 0;
    localparam int RTCAI_ALM_MIN = 1;
    localparam int RTCAI_ALM_HOUR = 2;
    localparam int RTCAI_ALM_DAY = 3;
    localparam int RTCAI_MASK_BIT = 7;

    // Control fields
    localparam int RTCAI_CTRL_OSC_STOP = 7;
    localparam int RTCAI_CTRL_WR_LOCK = 6;
    localparam int RTCAI_CTRL_ROUTE = 2;
    localparam int RTCAI_CTRL_ALARM1_IRQ_ENABLE = 1;
    localparam int RTCAI_CTRL_ALARM0_IRQ_ENABLE = 0;
    localparam logic [7:0] RTCAI_CTRL_RST = 8'h80;
    localparam logic [7:0] RTCAI_CTRL_USED = 8'hC7;

    // Status fields
    localparam int RTCAI_STAT_FLAG1 = 1;
    localparam int RTCAI_STAT_FLAG0 = 0;

    // Charger select fields and power-on pattern
    localparam int RTCAI_CHG_KEY_LSB = 4;
    localparam int RTCAI_CHG_DIODE_LSB = 2;
    localparam int RTCAI_CHG_RES_LSB = 0;
    localparam logic [3:0] RTCAI_CHG_KEY_ON = 4'hA;
    localparam logic [1:0] RTCAI_DIODE_ONE = 2'h1;
    localparam logic [1:0] RTCAI_DIODE_TWO = 2'h2;
    localparam logic [1:0] RTCAI_RES_OFF = 2'h0;
    localparam logic [7:0] RTCAI_CHG_RST = 8'h5C;

    // Alarm registers after reset
    localparam logic [7:0] RTCAI_ALM_RST = 8'h00;

endpackage : rtcai_pkg

// >>> hdl/rtcai_alarm_match.sv
/*
 * Match logic for one time-of-day alarm: compares four alarm bytes with
 * the current time, each field skipped when its mask bit is set.
 * Assumes time bytes are stable whenever the update tick is high.
 */
`timescale 1ns/100ps
module rtcai_alarm_match
    import rtcai_pkg::*;
(
    input wire logic update_tick, // One-cycle clock update
    input wire logic [7:0] alm_sec, // Alarm seconds byte, mask in bit 7
    input wire logic [7:0] alm_min, // Alarm minutes byte
    input wire logic [7:0] alm_hour, // Alarm hours byte
    input wire logic [7:0] alm_day, // Alarm day byte
    input wire logic [7:0] time_sec, // Current seconds
    input wire logic [7:0] time_min, // Current minutes
    input wire logic [7:0] time_hour, // Current hours
    input wire logic [7:0] time_day, // Current day
    output logic match // High on a tick that matches
);

    function automatic logic field_ok(input logic [7:0] alm, input logic [7:0] cur);
        field_ok = alm[RTCAI_MASK_BIT] | (alm[6:0] == cur[6:0]);
    endfunction : field_ok

    wire sec_ok = field_ok(alm_sec, time_sec);
    wire min_ok = field_ok(alm_min, time_min);
    wire hour_ok = field_ok(alm_hour, time_hour);
    wire day_ok = field_ok(alm_day, time_day);

    // All masks set: every tick; masks cleared fields must also agree
    assign match = update_tick & sec_ok & min_ok & hour_ok & day_ok;

endmodule : rtcai_alarm_match

// >>> hdl/rtcai_top.sv
/*
 * Alarm match, interrupt routing, control, status and charger select
 * registers of a serial real-time clock.
 * Assumes the serial engine and timekeeping counters run on sys_clk and
 * hand over pointer, write and tick pulses without synchronisation.
 */
`timescale 1ns/100ps
module rtcai_top
    import rtcai_pkg::*;
#(
    parameter int NUM_ALARMS = 2 // Time-of-day alarms
) (
    input wire logic sys_clk, // 20 MHz clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic update_tick, // One-cycle pulse on each clock update
    input wire logic [7:0] time_sec, // Current seconds byte
    input wire logic [7:0] time_min, // Current minutes byte
    input wire logic [7:0] time_hour, // Current hours byte
    input wire logic [7:0] time_day, // Current day byte
    input wire logic [7:0] ptr_addr, // Serial address pointer, bit 7 = write
    input wire logic ptr_strobe, // Pulse: pointer has reached ptr_addr
    input wire logic wr_strobe, // Pulse: write wr_data at ptr_addr
    input wire logic [7:0] wr_data, // Write data byte
    output logic [7:0] rd_data, // Read data for ptr_addr
    output logic oscillator_stop, // High halts oscillator, standby
    output logic write_lock, // High while writes are blocked
    output logic irq_out_first_n, // First interrupt, active low
    output logic irq_out_second_n, // Second interrupt, active low
    output logic charger_enable, // Trickle charger on
    output logic [1:0] diode_count_select, // Diode code
    output logic [1:0] resistor_choice // Resistor code
);

    localparam int ALM_TOTAL = NUM_ALARMS * RTCAI_ALM_REGS;

    // True when the address falls in one alarm's four registers
    function automatic logic in_alarm(input logic [6:0] ofs, input logic [6:0] base);
        in_alarm = (ofs >= base) && (ofs < base + RTCAI_ALM_SPAN);
    endfunction : in_alarm

    logic [7:0] alarm_ff [ALM_TOTAL];
    logic [7:0] nxt_alarm [ALM_TOTAL];
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [7:0] chg_ff;
    logic [7:0] nxt_chg;
    logic [NUM_ALARMS-1:0] flag_ff;
    logic [NUM_ALARMS-1:0] nxt_flag;
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;
    logic irq_first_n_ff;
    logic irq_second_n_ff;
    logic chg_on_ff;
    logic [NUM_ALARMS-1:0] alm_match;
    logic [NUM_ALARMS-1:0] alm_clear;

    // Address decode
    wire [6:0] ofs = ptr_addr[6:0];
    wire is_write = ptr_addr[RTCAI_WR_BIT];
    wire wr_ok = wr_strobe & is_write & ~ctrl_ff[RTCAI_CTRL_WR_LOCK];
    wire hit_alarm = in_alarm(ofs, RTCAI_OFS_ALM0) | in_alarm(ofs, RTCAI_OFS_ALM1);
    wire hit_ctrl = (ofs == RTCAI_OFS_CTRL);
    wire hit_stat = (ofs == RTCAI_OFS_STAT);
    wire hit_chg = (ofs == RTCAI_OFS_CHG);
    wire [6:0] alm_ofs = ofs - RTCAI_OFS_ALM0;
    wire [2:0] alm_idx = alm_ofs[2:0];

    // Control fields
    wire route_sel = ctrl_ff[RTCAI_CTRL_ROUTE];
    wire alarm0_irq_enable = ctrl_ff[RTCAI_CTRL_ALARM0_IRQ_ENABLE];
    wire alarm1_irq_enable = ctrl_ff[RTCAI_CTRL_ALARM1_IRQ_ENABLE];

    // Charger fields
    wire [3:0] chg_key = chg_ff[RTCAI_CHG_KEY_LSB +: 4];
    wire [1:0] chg_diode = chg_ff[RTCAI_CHG_DIODE_LSB +: 2];
    wire [1:0] chg_res = chg_ff[RTCAI_CHG_RES_LSB +: 2];
    wire key_ok = (chg_key == RTCAI_CHG_KEY_ON);
    wire diode_ok = (chg_diode == RTCAI_DIODE_ONE) | (chg_diode == RTCAI_DIODE_TWO);
    wire res_ok = (chg_res != RTCAI_RES_OFF);
    wire nxt_chg_on = key_ok & diode_ok & res_ok;

    // Interrupt routing
    wire req0 = flag_ff[0] & alarm0_irq_enable;
    wire req1 = flag_ff[1] & alarm1_irq_enable;
    wire nxt_irq_first_n = ~(req0 | (~route_sel & req1));
    wire nxt_irq_second_n = ~(route_sel & req1);

    // Status byte with upper bits zero
    wire [7:0] stat_byte = {6'h00, flag_ff[1], flag_ff[0]};

    // Match engines, one per alarm
    genvar ga;
    generate
        for (ga = 0; ga < NUM_ALARMS; ga++) begin : g_alarm
            localparam int B = ga * RTCAI_ALM_REGS;
            rtcai_alarm_match u_match (
                .update_tick(update_tick),
                .alm_sec(alarm_ff[B + RTCAI_ALM_SEC]),
                .alm_min(alarm_ff[B + RTCAI_ALM_MIN]),
                .alm_hour(alarm_ff[B + RTCAI_ALM_HOUR]),
                .alm_day(alarm_ff[B + RTCAI_ALM_DAY]),
                .time_sec(time_sec),
                .time_min(time_min),
                .time_hour(time_hour),
                .time_day(time_day),
                .match(alm_match[ga])
            );
            // Pointer landing on this alarm's registers, read or write
            assign alm_clear[ga] = ptr_strobe &
                in_alarm(ofs, 7'(RTCAI_OFS_ALM0 + 7'(B)));
            // A match in the clearing cycle still sets the flag
            assign nxt_flag[ga] = alm_match[ga] | (flag_ff[ga] & ~alm_clear[ga]);
        end
    endgenerate

    // Alarm register writes
    always_comb begin
        for (int i = 0; i < ALM_TOTAL; i++) begin
            nxt_alarm[i] = alarm_ff[i];
        end
        if (wr_ok && hit_alarm) begin
            nxt_alarm[alm_idx] = wr_data;
        end
    end

    // Control write; lock bit stays writable so software can unlock
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_strobe && is_write && hit_ctrl) begin
            if (ctrl_ff[RTCAI_CTRL_WR_LOCK]) begin
                nxt_ctrl[RTCAI_CTRL_WR_LOCK] = wr_data[RTCAI_CTRL_WR_LOCK];
            end else begin
                nxt_ctrl = wr_data & RTCAI_CTRL_USED;
            end
        end
    end

    // Charger write
    always_comb begin
        nxt_chg = chg_ff;
        if (wr_ok && hit_chg) begin
            nxt_chg = wr_data;
        end
    end

    // Read data for the current pointer
    always_comb begin
        nxt_rd_data = 8'h00;
        if (!is_write) begin
            if (hit_alarm) begin
                nxt_rd_data = alarm_ff[alm_idx];
            end else if (hit_ctrl) begin
                nxt_rd_data = ctrl_ff;
            end else if (hit_stat) begin
                nxt_rd_data = stat_byte;
            end else if (hit_chg) begin
                nxt_rd_data = chg_ff;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ALM_TOTAL; i++) begin
                alarm_ff[i] <= RTCAI_ALM_RST;
            end
        end else begin
            alarm_ff <= nxt_alarm;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= RTCAI_CTRL_RST;
            chg_ff <= RTCAI_CHG_RST;
            flag_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            chg_ff <= nxt_chg;
            flag_ff <= nxt_flag;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= 8'h00;
            irq_first_n_ff <= 1'b1;
            irq_second_n_ff <= 1'b1;
            chg_on_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            irq_first_n_ff <= nxt_irq_first_n;
            irq_second_n_ff <= nxt_irq_second_n;
            chg_on_ff <= nxt_chg_on;
        end
    end

    assign rd_data = rd_data_ff;
    assign oscillator_stop = ctrl_ff[RTCAI_CTRL_OSC_STOP];
    assign write_lock = ctrl_ff[RTCAI_CTRL_WR_LOCK];
    assign irq_out_first_n = irq_first_n_ff;
    assign irq_out_second_n = irq_second_n_ff;
    assign charger_enable = chg_on_ff;
    assign diode_count_select = chg_diode;
    assign resistor_choice = chg_res;

endmodule : rtcai_top

// >>> verification/rtcai_top_asserts.sv
/* Port assertions for rtcai_top.
   Bound into every rtcai_top instance. */
`timescale 1ns/100ps
module rtcai_top_chk
    import rtcai_pkg::*;
#(
    parameter int NUM_ALARMS = 2 // Alarms
) (
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic update_tick, // Tick
    input wire logic [7:0] ptr_addr, // Pointer
    input wire logic wr_strobe, // Write
    input wire logic [7:0] wr_data, // Data
    input wire logic [7:0] rd_data, // Read data
    input wire logic oscillator_stop, // Stop
    input wire logic write_lock, // Lock
    input wire logic irq_out_first_n, // Irq
    input wire logic charger_enable, // Charger
    input wire logic [1:0] diode_count_select, // Diodes
    input wire logic [1:0] resistor_choice // Resistor
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    osc_reset_a: assert property ($rose(rst_n) |-> oscillator_stop)
        else $error("oscillator running after reset");
    chg_reset_a: assert property ($rose(rst_n) |-> !charger_enable && diode_count_select == 2'h3
        && resistor_choice == 2'h0) else $error("charger not in power-on state");
    chg_codes_a: assert property (charger_enable && $stable(diode_count_select)
        && $stable(resistor_choice) |-> diode_count_select inside {2'h1, 2'h2}
        && resistor_choice != 2'h0) else $error("charger on with disabling code");
    lock_chg_a: assert property (write_lock && wr_strobe && ptr_addr == 8'h91
        |=> $stable(diode_count_select) && $stable(resistor_choice))
        else $error("charger written while locked");
    lock_osc_a: assert property (write_lock && wr_strobe && ptr_addr == 8'h8F
        |=> $stable(oscillator_stop)) else $error("stop bit written while locked");
    osc_set_a: assert property (!write_lock && wr_strobe && ptr_addr == 8'h8F && wr_data[7]
        |=> oscillator_stop) else $error("stop bit not set");
    osc_clr_a: assert property (!write_lock && wr_strobe && ptr_addr == 8'h8F && !wr_data[7]
        |=> !oscillator_stop) else $error("stop bit not cleared");
    status_zero_a: assert property (ptr_addr == 8'h10 |=> rd_data[7:2] == 6'h00)
        else $error("status upper bits not zero");
    first_fall_a: assert property ($fell(irq_out_first_n) |->
        $past(update_tick, 2) || $past(wr_strobe, 2)) else $error("first irq fell without cause");
endmodule : rtcai_top_chk

bind rtcai_top rtcai_top_chk #(.NUM_ALARMS(NUM_ALARMS)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .update_tick(update_tick), .ptr_addr(ptr_addr),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data),
    .oscillator_stop(oscillator_stop), .write_lock(write_lock),
    .irq_out_first_n(irq_out_first_n), .charger_enable(charger_enable),
    .diode_count_select(diode_count_select), .resistor_choice(resistor_choice)
);

// >>> verification/rtcai_host_model.sv
/* Host side of the register access: pointer, write and read cycles.
   Assumes one access at a time, driven at the falling edge. */
`timescale 1ns/100ps
module rtcai_host_model (
    input wire logic sys_clk, // Clock
    input wire logic [7:0] rd_data, // Read data
    output logic [7:0] ptr_addr, // Pointer
    output logic ptr_strobe, // Pointer event
    output logic wr_strobe, // Write pulse
    output logic [7:0] wr_data // Write data
);
    initial begin
        ptr_addr = 8'h7F;
        ptr_strobe = 1'b0;
        wr_strobe = 1'b0;
        wr_data = 8'h00;
    end

    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge sys_clk);
        ptr_addr = a;
        ptr_strobe = 1'b1;
        wr_strobe = w;
        wr_data = d;
        @(negedge sys_clk);
        ptr_strobe = 1'b0;
        wr_strobe = 1'b0;
        wr_data = ~d; // Released data does not keep its value
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        acc(a, 8'h00, 1'b0);
        d = rd_data;
    endtask : rd
endmodule : rtcai_host_model

// >>> verification/tb_rtc_alarm_interrupt_control.sv
/* Bench for rtcai_top: host model drives register access,
   bench drives time bytes and update ticks. */
`timescale 1ns/100ps
module tb_rtc_alarm_interrupt_control
    import rtcai_pkg::*;
    ;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic update_tick = 1'b0;
    logic [7:0] t_sec = 8'h00, t_min = 8'h00, t_hour = 8'h00, t_day = 8'h00, rv;
    logic [7:0] codes[10] = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hAA, 8'hAB, 8'h55, 8'hA4, 8'hA1,
        8'hAD};
    wire [7:0] ptr_addr, wr_data, rd_data;
    wire ptr_strobe, wr_strobe, osc_stop, wr_lock, irq1_n, irq2_n, chg_en;
    wire [1:0] diode, res;
    int n_fail = 0, check_count = 0, cyc = 0;

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    rtcai_top #(.NUM_ALARMS(2)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .update_tick(update_tick),
        .time_sec(t_sec), .time_min(t_min), .time_hour(t_hour), .time_day(t_day),
        .ptr_addr(ptr_addr), .ptr_strobe(ptr_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data),
        .rd_data(rd_data), .oscillator_stop(osc_stop), .write_lock(wr_lock),
        .irq_out_first_n(irq1_n), .irq_out_second_n(irq2_n), .charger_enable(chg_en),
        .diode_count_select(diode), .resistor_choice(res));
    rtcai_host_model host (.sys_clk(sys_clk), .rd_data(rd_data), .ptr_addr(ptr_addr),
        .ptr_strobe(ptr_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data));

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask : rchk

    task automatic tick(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h,
        input logic [7:0] d);
        @(negedge sys_clk);
        t_sec = s;
        t_min = m;
        t_hour = h;
        t_day = d;
        update_tick = 1'b1;
        @(negedge sys_clk);
        update_tick = 1'b0;
    endtask : tick

    // Fields below k compared; masked fields and one missed field are off by one
    task automatic alarm_case(input int k, input logic hit);
        logic [7:0] v[4] = '{8'h12, 8'h34, 8'h05, 8'h03};
        logic [7:0] t[4];
        for (int i = 0; i < 4; i++) begin
            host.wr(8'(8'h87 + i), {i >= k, v[i][6:0]});
            t[i] = (i < k && (hit || i != k - 1)) ? v[i] : v[i] + 8'h01;
        end
        tick(t[0], t[1], t[2], t[3]);
        @(negedge sys_clk);
        chk(irq1_n, !hit);
    endtask : alarm_case

    initial begin
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk(osc_stop, 1'b1);
        chk({chg_en, diode, res, irq1_n, irq2_n}, 8'h33);
        rchk(8'h11, RTCAI_CHG_RST);
        rchk(8'h0F, RTCAI_CTRL_RST);
        host.wr(8'h8F, 8'h00);
        chk(osc_stop, 1'b0);
        foreach (codes[i]) begin
            host.wr(8'h91, codes[i]);
            @(negedge sys_clk);
            chk(chg_en, i < 6);
            chk({diode, res}, codes[i][3:0]);
        end
        host.wr(8'h8F, 8'h05);
        for (int k = 0; k < 5; k++) begin
            alarm_case(k, 1'b1);
            if (k > 0) alarm_case(k, 1'b0);
        end
        rchk(8'h0A, 8'h03);
        for (int i = 0; i < 4; i++) host.wr(8'(8'h8B + i), 8'h80);
        rchk(8'h0E, 8'h80);
        host.wr(8'h8F, 8'h06);
        tick(8'h01, 8'h01, 8'h01, 8'h01);
        repeat (6) @(negedge sys_clk);
        chk({irq1_n, irq2_n}, 8'h02);
        host.wr(8'h8F, 8'h02);
        @(negedge sys_clk);
        chk({irq1_n, irq2_n}, 8'h01);
        host.wr(8'h8F, 8'h04);
        tick(8'h12, 8'h34, 8'h05, 8'h03);
        @(negedge sys_clk);
        chk({irq1_n, irq2_n}, 8'h03);
        rchk(8'h10, 8'h03);
        host.rd(8'h07, rv);
        rchk(8'h10, 8'h02);
        host.rd(8'h0E, rv);
        rchk(8'h10, 8'h00);
        host.wr(8'h8F, 8'h40);
        chk(wr_lock, 1'b1);
        host.wr(8'h91, 8'hA6);
        host.wr(8'h8F, 8'hC0);
        rchk(8'h11, 8'hAD);
        rchk(8'h0F, 8'h40);
        host.wr(8'h8F, 8'h80);
        chk({wr_lock, osc_stop}, 8'h00);
        give_verdict();
    end
endmodule : tb_rtc_alarm_interrupt_control
